// file: inc/drs_pkg.sv
/*
  constants and carrier types for the dram reset and power-up sequencer.
  assumes a 50 MHz core clock and a link clock supplied by the host.
*/
// Summary of operation
// - reset input low returns device to standby
// - reset restores configuration registers to defaults
// - self-refresh halted, array invalid during reset
// - reset forces exit from sleep and power-down
// - self-refresh restarts when reset goes high
// - reset reloads refresh row counter start value
// - low reset at power-up postpones init wait
package drs_pkg;

  localparam int    CLK_PERIOD_NS          = 20;
  localparam int    INIT_WAIT_TIME_US      = 150;
  localparam int    INIT_WAIT_CYCLES       =
    (INIT_WAIT_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int    RESET_TO_SELECT_TIME_NS   = 400;
  localparam int    RESET_TO_SELECT_CYCLES    =
    (RESET_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int    RELEASE_TO_SELECT_TIME_NS = 200;
  localparam int    RELEASE_TO_SELECT_CYCLES  =
    (RELEASE_TO_SELECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int    CNT_W       = 16;
  localparam int    ROW_W       = 13;
  localparam int    REFI_W      = 8;
  localparam int    CFG_W       = 16;

  localparam logic [ROW_W-1:0]  ROW_START    = 13'h0000;
  localparam logic [CFG_W-1:0]  CFG0_DEFAULT = 16'h8f1f;
  localparam logic [CFG_W-1:0]  CFG1_DEFAULT = 16'h0002;
  localparam logic [REFI_W-1:0] REFI_DEFAULT = 8'h4e;
  localparam logic [CNT_W-1:0]  CNT_ZERO     = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE      = 16'h0001;
  localparam logic [ROW_W-1:0]  ROW_ONE      = 13'h0001;
  localparam logic [REFI_W-1:0] REFI_ONE     = 8'h01;

  typedef enum logic [2:0]
  {
    ST_POWER_UP  = 3'b000,
    ST_IN_RESET  = 3'b001,
    ST_INIT_WAIT = 3'b010,
    ST_STANDBY   = 3'b011,
    ST_ACTIVE    = 3'b100,
    ST_SLEEP     = 3'b101,
    ST_DEEP_PD   = 3'b110
  } drs_state_type;

  // low-power requests decoded by the command logic elsewhere
  typedef struct packed
  {
    logic enter_sleep;
    logic enter_deep_pd;
    logic wake;
  } drs_pwr_req_type;

  typedef struct packed
  {
    logic [CFG_W-1:0] cfg0;
    logic [CFG_W-1:0] cfg1;
  } drs_cfg_type;

  typedef struct packed
  {
    logic             refresh_pulse;
    logic [ROW_W-1:0] refresh_row;
    logic             array_valid;
    logic             cmd_accept;
    drs_state_type    state;
  } drs_status_type;

endpackage

// file: hdl/drs_link_sync.sv
/*
  link-side select tracker: synchronises the accept level into the link
  clock and reports select activity back as a toggle.
  assumes the link clock only runs while the host frames a transaction.
*/
`timescale 1ns/10ps
module drs_link_sync
(
  // link side
  input  wire logic i_link_clk,
  input  wire logic i_cs_n,
  // core side
  input  wire logic i_accept,
  output logic      o_link_accept,
  output logic      o_frame_toggle
);
  import drs_pkg::*;

  typedef struct packed
  {
    logic acc_m;
    logic acc_s;
    logic toggle;
  } drs_link_reg_type;

  // power-up value only: the link clock may not run while core reset is held
  drs_link_reg_type r_q = '0;
  drs_link_reg_type r_d;
  // kept apart: the clock stops with the frame, so select itself clears it
  logic             in_frame_q = 1'b0;

  always_comb
  begin
    r_d       = r_q;
    r_d.acc_m = i_accept;
    r_d.acc_s = r_q.acc_m;
    // count a frame only once the core says commands are accepted
    if (!i_cs_n && !in_frame_q && r_q.acc_s)
    begin
      r_d.toggle = ~r_q.toggle;
    end
  end

  always_ff @(posedge i_link_clk)
  begin
    r_q <= r_d;
  end

  always_ff @(posedge i_link_clk or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      in_frame_q <= 1'b0;
    end
    else if (r_q.acc_s)
    begin
      in_frame_q <= 1'b1;
    end
  end

  assign o_link_accept  = r_q.acc_s;
  assign o_frame_toggle = r_q.toggle;
endmodule

// file: hdl/drs_sequencer.sv
/*
  reset and power-up sequencer of a self-refreshing serial dram.
  holds mode state, configuration defaults, refresh row counter and the
  gate that decides when host commands may be accepted.
  assumes i_reset_n and i_cs_n are asynchronous pins and i_link_clk is the
  host bus clock, unrelated to i_mclk.
*/
`timescale 1ns/10ps
module drs_sequencer
#(
  parameter int INIT_CYCLES = drs_pkg::INIT_WAIT_CYCLES,
  parameter int REFI_CYCLES = drs_pkg::REFI_DEFAULT
)
(
  // core clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  // device pins
  input  wire logic                    i_reset_n,
  input  wire logic                    i_cs_n,
  input  wire logic                    i_link_clk,
  // from command logic
  input  wire drs_pkg::drs_pwr_req_type i_pwr_req,
  input  wire logic                    i_cfg_we,
  input  wire drs_pkg::drs_cfg_type    i_cfg_wdata,
  // results
  output drs_pkg::drs_cfg_type         o_cfg,
  output drs_pkg::drs_status_type      o_status,
  output logic                         o_link_accept,
  output logic                         o_frame_seen
);
  import drs_pkg::*;

  typedef struct packed
  {
    drs_state_type      state;
    logic [CNT_W-1:0]   wait_cnt;
    logic [REFI_W-1:0]  refi_cnt;
    logic [ROW_W-1:0]   row;
    logic               refresh_pulse;
    logic               array_valid;
    drs_cfg_type        cfg;
    logic               rstn_m;
    logic               rstn_s;
    logic               csn_m;
    logic               csn_s;
    logic               tog_m;
    logic               tog_s;
    logic               tog_d;
    logic               frame_seen;
  } drs_core_reg_type;

  localparam logic [CNT_W-1:0]  INIT_LAST =
    CNT_W'(INIT_CYCLES - 1);
  localparam logic [REFI_W-1:0] REFI_LAST =
    REFI_W'(REFI_CYCLES - 1);

  drs_core_reg_type r_q;
  drs_core_reg_type r_d;
  logic             accept;
  logic             frame_toggle;
  logic             refresh_run;

  drs_link_sync u_link
  (
    .i_link_clk     (i_link_clk),
    .i_cs_n         (i_cs_n),
    .i_accept       (accept),
    .o_link_accept  (o_link_accept),
    .o_frame_toggle (frame_toggle)
  );

  // refresh runs in every state but power-up, reset and deep power-down
  assign refresh_run = (r_q.state != ST_IN_RESET)
                    && (r_q.state != ST_POWER_UP)
                    && (r_q.state != ST_DEEP_PD);
  assign accept = (r_q.state == ST_STANDBY)
               || (r_q.state == ST_ACTIVE);

  always_comb
  begin
    r_d               = r_q;
    r_d.rstn_m        = i_reset_n;
    r_d.rstn_s        = r_q.rstn_m;
    r_d.csn_m         = i_cs_n;
    r_d.csn_s         = r_q.csn_m;
    r_d.tog_m         = frame_toggle;
    r_d.tog_s         = r_q.tog_m;
    r_d.tog_d         = r_q.tog_s;
    r_d.refresh_pulse = 1'b0;
    r_d.frame_seen    = accept && (r_q.tog_s != r_q.tog_d);

    if (refresh_run)
    begin
      if (r_q.refi_cnt == REFI_LAST)
      begin
        r_d.refi_cnt      = '0;
        r_d.refresh_pulse = 1'b1;
        r_d.row           = r_q.row + ROW_ONE;
      end
      else
      begin
        r_d.refi_cnt = r_q.refi_cnt + REFI_ONE;
      end
    end

    if (!r_q.rstn_s)
    begin
      // reset pin low overrides any state, even sleep and deep pd
      r_d.state       = ST_IN_RESET;
      r_d.cfg.cfg0    = CFG0_DEFAULT;
      r_d.cfg.cfg1    = CFG1_DEFAULT;
      r_d.row         = ROW_START;
      r_d.refi_cnt    = '0;
      r_d.refresh_pulse = 1'b0;
      r_d.array_valid = 1'b0;
      r_d.wait_cnt    = CNT_ZERO;
    end
    else
    begin
      unique case (r_q.state)
        ST_POWER_UP,
        ST_IN_RESET:
        begin
          // init wait only starts once the pin is high
          r_d.state    = ST_INIT_WAIT;
          r_d.wait_cnt = CNT_ZERO;
        end
        ST_INIT_WAIT:
        begin
          // array is refreshed during this wait to initialise it
          if (r_q.wait_cnt == INIT_LAST)
          begin
            r_d.state       = ST_STANDBY;
            r_d.array_valid = 1'b1;
          end
          else
          begin
            r_d.wait_cnt = r_q.wait_cnt + CNT_ONE;
          end
        end
        ST_STANDBY:
        begin
          if (!r_q.csn_s)
          begin
            r_d.state = ST_ACTIVE;
          end
          else if (i_pwr_req.enter_deep_pd)
          begin
            r_d.state       = ST_DEEP_PD;
            r_d.array_valid = 1'b0;
          end
          else if (i_pwr_req.enter_sleep)
          begin
            r_d.state = ST_SLEEP;
          end
          if (i_cfg_we)
          begin
            r_d.cfg = i_cfg_wdata;
          end
        end
        ST_ACTIVE:
        begin
          if (r_q.csn_s)
          begin
            r_d.state = ST_STANDBY;
          end
          if (i_cfg_we)
          begin
            r_d.cfg = i_cfg_wdata;
          end
        end
        ST_SLEEP:
        begin
          if (i_pwr_req.wake)
          begin
            r_d.state = ST_STANDBY;
          end
        end
        ST_DEEP_PD:
        begin
          // deep pd loses contents; leaving it re-runs the init wait
          if (i_pwr_req.wake)
          begin
            r_d.state    = ST_INIT_WAIT;
            r_d.wait_cnt = CNT_ZERO;
          end
        end
        default:
        begin
          r_d.state = ST_IN_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      r_q          <= '0;
      r_q.state    <= ST_POWER_UP;
      r_q.cfg.cfg0 <= CFG0_DEFAULT;
      r_q.cfg.cfg1 <= CFG1_DEFAULT;
      r_q.row      <= ROW_START;
      r_q.csn_m    <= 1'b1;
      r_q.csn_s    <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_cfg                  = r_q.cfg;
  assign o_status.refresh_pulse = r_q.refresh_pulse;
  assign o_status.refresh_row   = r_q.row;
  assign o_status.array_valid   = r_q.array_valid;
  assign o_status.cmd_accept    = accept;
  assign o_status.state         = r_q.state;
  assign o_frame_seen           = r_q.frame_seen;
endmodule

// file: testbench/drs_sequencer_asserts.sv
/*
  port checker for drs_sequencer.
  assumes a bind from the bench top and one core clock domain.
*/
`timescale 1ns/10ps
module drs_sequencer_asserts
  import drs_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_WAIT_CYCLES
)
(
  input wire logic           i_mclk,
  input wire logic           i_rst,
  input wire logic           i_reset_n,
  input wire drs_cfg_type    o_cfg,
  input wire drs_status_type o_status,
  input wire logic           o_frame_seen
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [15:0] cnt_q;
  // length of the current init wait, cleared outside it
  always_ff @(posedge i_mclk)
    cnt_q <= (i_rst || o_status.state != ST_INIT_WAIT) ? 16'h0
             : cnt_q + 16'h1;
  AST_RST_STBY: assert property (!i_reset_n[*4] |=>
    o_status.state == ST_IN_RESET && !o_status.cmd_accept &&
    !o_status.refresh_pulse) else $error("pin low kept old mode");
  AST_CFG_DEF: assert property (!i_reset_n[*4] |=>
    o_cfg == {CFG0_DEFAULT, CFG1_DEFAULT}) else $error("cfg not default");
  AST_CLEAR: assert property (o_status.state == ST_IN_RESET |->
    o_status.refresh_row == ROW_START && !o_status.array_valid)
    else $error("row or valid kept in reset");
  AST_INIT_ENTRY: assert property (o_status.state == ST_IN_RESET |=>
    o_status.state inside {ST_IN_RESET, ST_INIT_WAIT})
    else $error("reset left without init wait");
  AST_INIT_LEN: assert property ($past(o_status.state) == ST_INIT_WAIT &&
    o_status.state == ST_STANDBY |-> cnt_q == 16'(INIT_CYCLES))
    else $error("init wait length wrong");
  AST_ACT_GATE: assert property (o_status.state == ST_ACTIVE |->
    $past(o_status.cmd_accept)) else $error("active without accept");
  AST_REFRESH: assert property ($rose(o_status.array_valid) |->
    ##[1:24] (o_status.refresh_pulse || !i_reset_n))
    else $error("refresh did not resume");
  AST_ROW_STEP: assert property ($changed(o_status.refresh_row) &&
    o_status.array_valid && $past(o_status.array_valid) |->
    o_status.refresh_row == $past(o_status.refresh_row) + 13'h1)
    else $error("row counter jumped");
  COV_STBY: cover property (o_status.state == ST_STANDBY);
  COV_SLEEP_RST: cover property (o_status.state == ST_SLEEP
    ##[1:40] o_status.state == ST_IN_RESET);
  COV_FRAME: cover property (o_frame_seen);
endmodule

// file: testbench/drs_host_model.sv
/*
  host controller model driving reset pin, select and link clock.
  assumes the bench calls one task at a time.
*/
`timescale 1ns/10ps
module drs_host_model
(
  output logic o_reset_n,
  output logic o_cs_n,
  output logic o_link_clk
);
  initial
  begin
    o_reset_n = 1'b1;
    o_cs_n = 1'b1;
    o_link_clk = 1'b0;
  end
  // select stays high through the low time and the recovery
  task automatic pin_reset(input int low_ns);
    o_reset_n = 1'b0;
    #(low_ns);
    o_reset_n = 1'b1;
    #200;
  endtask
  // link clock runs only inside a frame, so it is stopped between them
  task automatic frame(input int n);
    o_cs_n = 1'b0;
    repeat (n)
    begin
      #32 o_link_clk = 1'b1;
      #32 o_link_clk = 1'b0;
    end
    #16 o_cs_n = 1'b1;
  endtask
endmodule

// file: testbench/test_drs_sequencer.sv
/*
  self-checking bench for drs_sequencer with a host model on the pins.
  assumes checker and host model are compiled first.
*/
`timescale 1ns/10ps
module test_drs_sequencer;
  import drs_pkg::*;
  logic            i_mclk = 1'b0;
  logic            i_rst = 1'b1;
  logic            i_cfg_we;
  drs_pwr_req_type i_pwr_req;
  drs_cfg_type     i_cfg_wdata, o_cfg, cfg_last, v;
  drs_status_type  o_status;
  logic            i_reset_n, i_cs_n, i_link_clk, o_link_accept, o_frame_seen;
  drs_cfg_type     exp_q[$];
  int              n_errors = 0, checks_done = 0, frames = 0, seed = 32'h558e;
  always #10 i_mclk = ~i_mclk;
  drs_sequencer #(.INIT_CYCLES(20), .REFI_CYCLES(20)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
    .i_link_clk(i_link_clk), .i_pwr_req(i_pwr_req), .i_cfg_we(i_cfg_we),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg(o_cfg), .o_status(o_status),
    .o_link_accept(o_link_accept), .o_frame_seen(o_frame_seen));
  drs_host_model host_u (.o_reset_n(i_reset_n), .o_cs_n(i_cs_n),
    .o_link_clk(i_link_clk));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wait_st(input drs_state_type s);
    int k;
    k = 0;
    while (o_status.state !== s && k < 3000)
    begin
      @(negedge i_mclk);
      k++;
    end
    chk(k < 3000, "state wait");
    if (k >= 3000)
      end_sim();
  endtask
  task automatic cfg_wr(input drs_cfg_type d);
    @(posedge i_mclk);
    i_cfg_we <= 1'b1;
    i_cfg_wdata <= d;
    @(posedge i_mclk);
    i_cfg_we <= 1'b0;
  endtask
  // every cfg change must match the oldest queued note
  always @(negedge i_mclk)
  begin
    if (o_frame_seen === 1'b1)
      frames++;
    if (!i_rst && o_cfg !== cfg_last)
    begin
      chk(exp_q.size() > 0 && o_cfg === exp_q.pop_front(),
          "cfg value");
      cfg_last = o_cfg;
    end
  end
  initial
  begin
    i_cfg_we <= 1'b0;
    i_pwr_req <= '0;
    i_cfg_wdata <= '0;
    cfg_last = {CFG0_DEFAULT, CFG1_DEFAULT};
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    wait_st(ST_INIT_WAIT);
    host_u.frame(4);
    wait_st(ST_STANDBY);
    chk(frames == 0 && o_status.array_valid === 1'b1, "init gate");
    chk(o_link_accept === 1'b0, "link accept early");
    // two frames back to back: the second must be counted as well
    repeat (2)
    begin
      host_u.frame(4);
      repeat (10) @(negedge i_mclk);
    end
    chk(frames == 2 && o_link_accept === 1'b1, "frame in standby");
    $display("test init done");
    v = drs_cfg_type'($random(seed));
    exp_q.push_back(v);
    cfg_wr(v);
    repeat (4) @(negedge i_mclk);
    exp_q.push_back({CFG0_DEFAULT, CFG1_DEFAULT});
    host_u.pin_reset(400);
    chk(exp_q.size() == 0, "cfg restored");
    wait_st(ST_STANDBY);
    exp_q.push_back(v);
    cfg_wr(v);
    // the first pin reset of the loop below brings the defaults back
    exp_q.push_back({CFG0_DEFAULT, CFG1_DEFAULT});
    $display("test reset done");
    // bit 1 picks deep power-down, bit 0 leaves by wake instead of pin
    for (int m = 0; m < 4; m++)
    begin
      repeat (30) @(posedge i_mclk);
      i_pwr_req <= drs_pwr_req_type'(m[1] ? 3'b010 : 3'b100);
      wait_st(m[1] ? ST_DEEP_PD : ST_SLEEP);
      @(posedge i_mclk);
      i_pwr_req <= '0;
      cfg_wr(drs_cfg_type'($random(seed)));
      if (m[0])
      begin
        i_pwr_req <= drs_pwr_req_type'(3'b001);
        wait_st(m[1] ? ST_INIT_WAIT : ST_STANDBY);
        @(posedge i_mclk);
        i_pwr_req <= '0;
      end
      else
      begin
        fork host_u.pin_reset(400); join_none
        wait_st(ST_IN_RESET);
      end
      wait_st(ST_STANDBY);
    end
    $display("test low power done");
    @(posedge i_mclk);
    i_rst <= 1'b1;
    fork host_u.pin_reset(2000); join_none
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    repeat (40) @(negedge i_mclk);
    chk(o_status.state === ST_IN_RESET, "init postponed");
    wait_st(ST_STANDBY);
    $display("test power up done");
    chk(exp_q.size() == 0, "notes left");
    end_sim();
  end
endmodule
bind drs_sequencer drs_sequencer_asserts #(.INIT_CYCLES(INIT_CYCLES)) chk_u (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_reset_n(i_reset_n), .o_cfg(o_cfg),
  .o_status(o_status), .o_frame_seen(o_frame_seen));
